// [hdl/uaf_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-wide register port, 125 MHz main clock
// Notes: Definitions only
`ifndef UAF_MAP_SVH
`define UAF_MAP_SVH

`define UAF_ADDR_W 3
`define UAF_OFS_DATA 3'h0
`define UAF_OFS_FCR 3'h1
`define UAF_OFS_MCR 3'h2
`define UAF_OFS_STATUS 3'h3
`define UAF_OFS_RXLEVEL 3'h4
`define UAF_OFS_TXLEVEL 3'h5

`define UAF_FCR_FIFO_EN 0
`define UAF_FCR_DMA_SEL 3
`define UAF_FCR_MODE64 5
`define UAF_FCR_TRIG_LO 6
`define UAF_MCR_RTS 1
`define UAF_MCR_LOOP 4
`define UAF_MCR_AUTO 5

`define UAF_ST_RX_AVAIL 0
`define UAF_ST_TX_FULL 1
`define UAF_ST_CTS_ON 2
`define UAF_ST_CTS_DELTA 3
`define UAF_ST_RTS_ON 4
`define UAF_ST_TX_BUSY 5

`define UAF_FCR_RESET 8'h00
`define UAF_MCR_RESET 8'h00

`define UAF_TRIG16_0 7'h01
`define UAF_TRIG16_1 7'h04
`define UAF_TRIG16_2 7'h08
`define UAF_TRIG16_3 7'h0E
`define UAF_TRIG64_0 7'h01
`define UAF_TRIG64_1 7'h10
`define UAF_TRIG64_2 7'h20
`define UAF_TRIG64_3 7'h38
`define UAF_CAP_CHAR 7'h01
`define UAF_CAP_16 7'h10
`define UAF_CAP_64 7'h40
`define UAF_RX_DEPTH 64

`define UAF_CLK_HZ 125000000
`define UAF_BAUD 115200
`define UAF_BIT_CYCLES (`UAF_CLK_HZ / `UAF_BAUD)
`define UAF_TX_DEPTH 8

`endif

// [hdl/uaf_pkg.sv]
// Purpose: Types for the autoflow serial block
// Assumes: Constants come from uaf_map.svh
// Notes: Types only
package uaf_pkg;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_START = 4'h2,
      TX_DATA = 4'h4,
      TX_STOP = 4'h8
   } uaf_tx_state_type;

   typedef struct packed {
      logic fcr_fifo_en;
      logic fcr_dma_sel;
      logic fcr_mode64;
      logic [1:0] fcr_trig;
      logic mcr_rts;
      logic mcr_loop;
      logic mcr_auto;
      logic cts_meta;
      logic cts_sync;
      logic cts_prev;
      logic cts_delta;
      logic rts_hold;
      logic rts_n;
      logic tx_out;
      logic dma_ready_n;
      uaf_tx_state_type tx_state;
      logic [7:0] tx_shift;
      logic [2:0] tx_bitcnt;
      logic [15:0] tx_tick;
      logic [7:0] rdata;
   } uaf_state_type;

endpackage : uaf_pkg

// [hdl/uaf_top.sv]
// Purpose: Autoflow control, transmit DMA ready and serial output
// Assumes: Receive bytes arrive already framed on the main clock
// Notes: Holds the FIFO module and the top module
//
// What this block does
// [RULE1] Serial output idles high from reset
// [RULE2] FIFO bit picks DMA type; char mode 0
// [RULE3] Mode 0 single transfers; mode 1 until full
// [RULE4] Write taken when selected and either strobe active
// [RULE5] Auto RTS active from empty until trigger reached
// [RULE6] Auto RTS drops at programmed trigger level
// [RULE7] Receiver keeps room for one extra byte
// [RULE8] Auto RTS returns once reads empty receive FIFO
// [RULE9] Auto CTS checked before each byte starts
// [RULE10] Remote releases CTS before last stop midpoint
// [RULE11] Byte in flight completes, next held off
// [RULE12] CTS low again resumes pending transmit data
// [RULE13] CTS changes raise no event under flow control
// [RULE14] Modem control bit 5 enables both autoflow modes
// [RULE15] Without auto CTS transmitter ignores CTS
// [RULE16] RTS from bit 1; off on reset, loop
// [RULE17] Autoflow works only with FIFOs enabled
`timescale 1ns/1ps
`include "uaf_map.svh"
`default_nettype none

module uaf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } uaf_fifo_state_type;

   uaf_fifo_state_type f_reg;
   uaf_fifo_state_type f_next;
   logic do_push;
   logic do_pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("uaf_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   assign in_ready_o = (f_reg.count != (AW + 1)'(DEPTH));
   assign out_valid_o = (f_reg.count != '0);
   assign out_data_o = f_reg.mem[f_reg.rd_ptr];
   assign level_o = f_reg.count;
   assign do_push = in_valid_i && in_ready_o;
   assign do_pop = out_valid_o && out_ready_i;

   always_comb begin
      f_next = f_reg;
      if (flush_i) begin
         f_next.wr_ptr = '0;
         f_next.rd_ptr = '0;
         f_next.count = '0;
      end else begin
         if (do_push) begin
            f_next.mem[f_reg.wr_ptr] = in_data_i;
            f_next.wr_ptr = f_reg.wr_ptr + 1'b1;
         end
         if (do_pop) begin
            f_next.rd_ptr = f_reg.rd_ptr + 1'b1;
         end
         if (do_push && !do_pop) begin
            f_next.count = f_reg.count + 1'b1;
         end else if (do_pop && !do_push) begin
            f_next.count = f_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end
endmodule : uaf_fifo

module uaf_top #(
   parameter int TX_DEPTH = `UAF_TX_DEPTH,
   parameter int BIT_CYCLES = `UAF_BIT_CYCLES
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [`UAF_ADDR_W-1:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_sel_i,
   input wire logic write_strobe_n_i,
   input wire logic write_strobe_p_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_ready_o,
   input wire logic cts_n_i,
   output logic rts_n_o,
   output logic serial_tx_out_o,
   output logic tx_dma_ready_n_o,
   output logic modem_event_o
);
   localparam int TLW = $clog2(TX_DEPTH) + 1;
   localparam int RLW = $clog2(`UAF_RX_DEPTH) + 1;
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

   uaf_pkg::uaf_state_type s_reg;
   uaf_pkg::uaf_state_type s_next;
   logic wr_en;
   logic flow_on;
   logic flush;
   logic tx_push;
   logic tx_in_ready;
   logic tx_out_valid;
   logic tx_pop;
   logic [7:0] tx_out_data;
   logic [TLW-1:0] tx_level;
   logic rx_in_ready;
   logic rx_out_valid;
   logic rx_pop;
   logic [7:0] rx_out_data;
   logic [RLW-1:0] rx_level;
   logic [6:0] rx_cap;
   logic [6:0] tx_cap;
   logic [6:0] trig;
   logic tx_line;
   logic tick_end;

   initial begin
      if (TX_DEPTH < 2 || TX_DEPTH > 64 || BIT_CYCLES < 2
         || BIT_CYCLES > 65535) begin
         $error("uaf_top: TX_DEPTH or BIT_CYCLES out of range");
      end
   end

   function automatic logic wr_hit(input logic en,
      input logic [`UAF_ADDR_W-1:0] addr,
      input logic [`UAF_ADDR_W-1:0] target);
      return en && (addr == target);
   endfunction : wr_hit

   function automatic logic [6:0] uaf_capacity(input logic fifo_en,
      input logic m64);
      if (!fifo_en) begin
         return `UAF_CAP_CHAR;
      end else if (m64) begin
         return `UAF_CAP_64;
      end
      return `UAF_CAP_16;
   endfunction : uaf_capacity

   function automatic logic [6:0] uaf_trigger(input logic [1:0] sel,
      input logic m64);
      logic [6:0] t;
      t = '0;
      case (sel)
         2'h0: t = m64 ? `UAF_TRIG64_0 : `UAF_TRIG16_0;
         2'h1: t = m64 ? `UAF_TRIG64_1 : `UAF_TRIG16_1;
         2'h2: t = m64 ? `UAF_TRIG64_2 : `UAF_TRIG16_2;
         2'h3: t = m64 ? `UAF_TRIG64_3 : `UAF_TRIG16_3;
         default: t = `UAF_TRIG16_0;
      endcase
      return t;
   endfunction : uaf_trigger

   uaf_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .flush_i(flush),
      .in_valid_i(tx_push),
      .in_ready_o(tx_in_ready),
      .in_data_i(bus_wdata_i),
      .out_valid_o(tx_out_valid),
      .out_ready_i(tx_pop),
      .out_data_o(tx_out_data),
      .level_o(tx_level)
   );

   uaf_fifo #(.WIDTH(8), .DEPTH(`UAF_RX_DEPTH)) u_rx_fifo (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .flush_i(flush),
      .in_valid_i(rx_valid_i && rx_ready_o),
      .in_ready_o(rx_in_ready),
      .in_data_i(rx_data_i),
      .out_valid_o(rx_out_valid),
      .out_ready_i(rx_pop),
      .out_data_o(rx_out_data),
      .level_o(rx_level)
   );

   assign rx_cap = uaf_capacity(s_reg.fcr_fifo_en, s_reg.fcr_mode64);
   // Transmit room is also bounded by the physical FIFO depth
   assign tx_cap = (rx_cap < 7'(TX_DEPTH)) ? rx_cap : 7'(TX_DEPTH);
   assign trig = uaf_trigger(s_reg.fcr_trig, s_reg.fcr_mode64);
   // Room past the trigger absorbs a byte already under way
   assign rx_ready_o = rx_in_ready && (7'(rx_level) < rx_cap); // RULE7
   assign flow_on = s_reg.fcr_fifo_en && s_reg.mcr_auto; // RULE14 RULE17
   assign tick_end = (s_reg.tx_tick == BIT_LAST);

   assign bus_rdata_o = s_reg.rdata;
   assign rts_n_o = s_reg.rts_n;
   assign serial_tx_out_o = s_reg.tx_out;
   assign tx_dma_ready_n_o = s_reg.dma_ready_n;
   assign modem_event_o = s_reg.cts_delta;

   always_comb begin
      s_next = s_reg;
      tx_pop = 1'b0;
      rx_pop = 1'b0;
      flush = 1'b0;
      tx_line = 1'b1;
      wr_en = bus_sel_i && (!write_strobe_n_i || write_strobe_p_i); // RULE4
      tx_push = wr_hit(wr_en, bus_addr_i, `UAF_OFS_DATA)
         && (7'(tx_level) < tx_cap);
      s_next.rdata = 8'h00;

      // Control writes
      if (wr_hit(wr_en, bus_addr_i, `UAF_OFS_FCR)) begin
         s_next.fcr_fifo_en = bus_wdata_i[`UAF_FCR_FIFO_EN];
         s_next.fcr_dma_sel = bus_wdata_i[`UAF_FCR_DMA_SEL];
         s_next.fcr_mode64 = bus_wdata_i[`UAF_FCR_MODE64];
         s_next.fcr_trig = bus_wdata_i[`UAF_FCR_TRIG_LO+:2];
         flush = (bus_wdata_i[`UAF_FCR_FIFO_EN] != s_reg.fcr_fifo_en)
            || (bus_wdata_i[`UAF_FCR_MODE64] != s_reg.fcr_mode64);
      end
      if (wr_hit(wr_en, bus_addr_i, `UAF_OFS_MCR)) begin
         s_next.mcr_rts = bus_wdata_i[`UAF_MCR_RTS];
         s_next.mcr_loop = bus_wdata_i[`UAF_MCR_LOOP];
         s_next.mcr_auto = bus_wdata_i[`UAF_MCR_AUTO]; // RULE14
      end

      // Register reads, data valid in the next cycle only
      if (bus_rd_i) begin
         case (bus_addr_i)
            `UAF_OFS_DATA: begin
               s_next.rdata = rx_out_valid ? rx_out_data : 8'h00;
               rx_pop = rx_out_valid;
            end
            `UAF_OFS_FCR: begin
               s_next.rdata[`UAF_FCR_FIFO_EN] = s_reg.fcr_fifo_en;
               s_next.rdata[`UAF_FCR_DMA_SEL] = s_reg.fcr_dma_sel;
               s_next.rdata[`UAF_FCR_MODE64] = s_reg.fcr_mode64;
               s_next.rdata[`UAF_FCR_TRIG_LO+:2] = s_reg.fcr_trig;
            end
            `UAF_OFS_MCR: begin
               s_next.rdata[`UAF_MCR_RTS] = s_reg.mcr_rts;
               s_next.rdata[`UAF_MCR_LOOP] = s_reg.mcr_loop;
               s_next.rdata[`UAF_MCR_AUTO] = s_reg.mcr_auto;
            end
            `UAF_OFS_STATUS: begin
               s_next.rdata[`UAF_ST_RX_AVAIL] = rx_out_valid;
               s_next.rdata[`UAF_ST_TX_FULL] = !(7'(tx_level) < tx_cap);
               s_next.rdata[`UAF_ST_CTS_ON] = !s_reg.cts_sync;
               s_next.rdata[`UAF_ST_CTS_DELTA] = s_reg.cts_delta;
               s_next.rdata[`UAF_ST_RTS_ON] = !s_reg.rts_n;
               s_next.rdata[`UAF_ST_TX_BUSY] =
                  (s_reg.tx_state != uaf_pkg::TX_IDLE);
               s_next.cts_delta = 1'b0;
            end
            `UAF_OFS_RXLEVEL: s_next.rdata = 8'(rx_level);
            `UAF_OFS_TXLEVEL: s_next.rdata = 8'(tx_level);
            default: s_next.rdata = 8'h00;
         endcase
      end

      // Clear-to-send synchroniser and change flag, set beats clear
      s_next.cts_meta = cts_n_i;
      s_next.cts_sync = s_reg.cts_meta;
      s_next.cts_prev = s_reg.cts_sync;
      if ((s_reg.cts_sync != s_reg.cts_prev) && !flow_on) begin
         s_next.cts_delta = 1'b1; // RULE13
      end

      // Receive threshold hold with empty-only release
      if (!flow_on) begin
         s_next.rts_hold = 1'b0;
      end else if (7'(rx_level) >= trig) begin
         s_next.rts_hold = 1'b1; // RULE6
      end else if (rx_level == '0) begin
         s_next.rts_hold = 1'b0; // RULE8
      end
      s_next.rts_n = !(s_reg.mcr_rts && !s_reg.mcr_loop
         && !(flow_on && s_next.rts_hold)); // RULE5 RULE16

      // Transmit shifter
      case (s_reg.tx_state)
         uaf_pkg::TX_IDLE: begin
            tx_line = 1'b1;
            if (tx_out_valid && (!flow_on || !s_reg.cts_sync)) begin
               tx_pop = 1'b1; // RULE9 RULE12 RULE15
               s_next.tx_shift = tx_out_data;
               s_next.tx_tick = 16'h0000;
               s_next.tx_state = uaf_pkg::TX_START;
            end
         end
         uaf_pkg::TX_START: begin
            tx_line = 1'b0;
            s_next.tx_tick = tick_end ? 16'h0000 : s_reg.tx_tick + 16'h0001;
            if (tick_end) begin
               s_next.tx_bitcnt = 3'h0;
               s_next.tx_state = uaf_pkg::TX_DATA;
            end
         end
         uaf_pkg::TX_DATA: begin
            // CTS is not looked at here, so a byte is never cut short
            tx_line = s_reg.tx_shift[0]; // RULE11
            s_next.tx_tick = tick_end ? 16'h0000 : s_reg.tx_tick + 16'h0001;
            if (tick_end) begin
               s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
               s_next.tx_bitcnt = s_reg.tx_bitcnt + 3'h1;
               if (s_reg.tx_bitcnt == 3'h7) begin
                  s_next.tx_state = uaf_pkg::TX_STOP;
               end
            end
         end
         uaf_pkg::TX_STOP: begin
            tx_line = 1'b1;
            s_next.tx_tick = tick_end ? 16'h0000 : s_reg.tx_tick + 16'h0001;
            if (tick_end) begin
               s_next.tx_state = uaf_pkg::TX_IDLE;
            end
         end
         default: begin
            tx_line = 1'b1;
            s_next.tx_state = uaf_pkg::TX_IDLE;
         end
      endcase
      s_next.tx_out = s_reg.mcr_loop ? 1'b1 : tx_line; // RULE1

      // Transmit DMA ready: mode 1 only with FIFOs on
      if (s_reg.fcr_fifo_en && s_reg.fcr_dma_sel) begin
         s_next.dma_ready_n = !(7'(tx_level) < tx_cap); // RULE2 RULE3
      end else begin
         s_next.dma_ready_n = (tx_level != '0); // RULE2 RULE3
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg <= '0;
         s_reg.fcr_fifo_en <= 1'(`UAF_FCR_RESET >> `UAF_FCR_FIFO_EN);
         s_reg.mcr_rts <= 1'b0;
         s_reg.cts_meta <= 1'b1;
         s_reg.cts_sync <= 1'b1;
         s_reg.cts_prev <= 1'b1;
         s_reg.rts_n <= 1'b1; // RULE16
         s_reg.tx_out <= 1'b1; // RULE1
         s_reg.dma_ready_n <= 1'b0;
         s_reg.tx_state <= uaf_pkg::TX_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   chk_idle_mark: assert property ( // RULE1
      (s_reg.tx_state == uaf_pkg::TX_IDLE) ##1
      (s_reg.tx_state == uaf_pkg::TX_IDLE) |-> serial_tx_out_o)
      else $error("serial output not marking while idle");

   chk_cts_gate: assert property ( // RULE9
      (s_reg.tx_state == uaf_pkg::TX_IDLE) && flow_on && s_reg.cts_sync
      |=> (s_reg.tx_state == uaf_pkg::TX_IDLE))
      else $error("byte started while clear-to-send inactive");

   chk_no_abort: assert property ( // RULE11
      (s_reg.tx_state == uaf_pkg::TX_DATA) && !$past(s_reg.mcr_loop)
      |=> (s_reg.tx_state == uaf_pkg::TX_DATA)
      || (s_reg.tx_state == uaf_pkg::TX_STOP))
      else $error("byte in flight was aborted");

   chk_free_send: assert property ( // RULE15
      (s_reg.tx_state == uaf_pkg::TX_IDLE) && !flow_on && tx_out_valid
      |=> (s_reg.tx_state == uaf_pkg::TX_START))
      else $error("transmitter held without auto clear-to-send");

   chk_rts_trigger: assert property ( // RULE6
      flow_on && (7'(rx_level) >= trig) |=> rts_n_o)
      else $error("request-to-send still active at trigger");

   chk_rts_empty: assert property ( // RULE8
      flow_on && s_reg.mcr_rts && !s_reg.mcr_loop && (rx_level == '0)
      |=> !rts_n_o)
      else $error("request-to-send not back after empty");

   chk_rts_manual: assert property ( // RULE16
      !s_reg.mcr_rts || s_reg.mcr_loop |=> rts_n_o)
      else $error("request-to-send active while disabled");

   chk_dma_full: assert property ( // RULE3
      s_reg.fcr_fifo_en && s_reg.fcr_dma_sel && (7'(tx_level) >= tx_cap)
      |=> tx_dma_ready_n_o)
      else $error("dma ready active with transmit FIFO full");

   chk_dma_char: assert property ( // RULE2
      !s_reg.fcr_fifo_en && (tx_level != '0) |=> tx_dma_ready_n_o)
      else $error("character mode dma ready not mode 0");

   chk_no_delta: assert property ( // RULE13
      flow_on && !s_reg.cts_delta |=> !s_reg.cts_delta)
      else $error("clear-to-send change flagged under flow control");

   chk_write_mcr: assert property ( // RULE4
      wr_hit(wr_en, bus_addr_i, `UAF_OFS_MCR)
      |=> s_reg.mcr_auto == $past(bus_wdata_i[`UAF_MCR_AUTO]))
      else $error("modem control write not taken");
endmodule : uaf_top

`default_nettype wire

// [dv/uaf_remote.sv]
// Purpose: Remote serial party with request and clear-to-send handshake
// Assumes: 8N1 line, BIT_CYCLES main clocks per bit
// Notes: Received count and last byte are visible to the bench
`timescale 1ns/1ps
`default_nettype none

module uaf_remote #(
   parameter int BIT_CYCLES = 4
) (
   input wire logic mclk_i,
   input wire logic line_i,
   input wire logic rts_n_i,
   input wire logic rx_ready_i,
   input wire logic send_en_i,
   input wire logic cts_hold_i,
   output logic cts_n_o,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic [7:0] got_o,
   output logic [7:0] got_cnt_o
);
   // Bench raises hold well before the stop bit midpoint
   assign cts_n_o = cts_hold_i;

   // Line decoder, sampled on the falling edge away from updates
   initial begin
      got_cnt_o = 8'h00;
      got_o = 8'h00;
      forever begin
         @(negedge mclk_i);
         if (line_i === 1'b0) begin
            repeat (BIT_CYCLES + BIT_CYCLES / 2 - 1) @(negedge mclk_i);
            for (int i = 0; i < 8; i++) begin
               got_o[i] = line_i;
               repeat (BIT_CYCLES) @(negedge mclk_i);
            end
            got_cnt_o = got_cnt_o + 8'h01;
         end
      end
   end

   // Sender checks request-to-send only before each byte, so one
   // more byte may follow the drop
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      forever begin
         @(posedge mclk_i);
         if (rx_valid_o && rx_ready_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= rx_data_o + 8'h01;
         end else if (!rx_valid_o && send_en_i && !rts_n_i) begin
            rx_valid_o <= 1'b1;
         end
      end
   end
endmodule : uaf_remote

`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Bench for autoflow control, DMA ready and serial output
// Assumes: Remote party model on the serial side, short bit time
// Notes: Registers reached through the plain strobe port
`timescale 1ns/1ps
`include "uaf_map.svh"
`default_nettype none
`define CHK(nm, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
   end \
end
`define WAITC(nm, cond, lim) begin \
   int k; \
   k = 0; \
   while (((cond) !== 1'b1) && (k < lim)) begin \
      pause(1); \
      k++; \
   end \
   `CHK(nm, 1'b1, (cond)) \
   if ((cond) !== 1'b1) give_verdict(); \
end

module tb_top;
   logic mclk, arst_n, bus_sel, wr_n, wr_p, bus_rd;
   logic [`UAF_ADDR_W-1:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, rx_data, got, got_cnt, d, n, rx_exp;
   logic rx_valid, rx_ready, cts_n, rts_n, serial_tx_out, dma_n, mod_ev;
   logic send_en, cts_hold;
   logic [7:0] trig_fcr [8];
   logic [6:0] trig_lvl [8];
   int checked, err_total;

   uaf_top #(.TX_DEPTH(8), .BIT_CYCLES(4)) i_uaf_top (
      .mclk_i(mclk), .arst_n_i(arst_n), .bus_addr_i(bus_addr),
      .bus_wdata_i(bus_wdata), .bus_sel_i(bus_sel),
      .write_strobe_n_i(wr_n), .write_strobe_p_i(wr_p),
      .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata), .rx_valid_i(rx_valid),
      .rx_data_i(rx_data), .rx_ready_o(rx_ready), .cts_n_i(cts_n),
      .rts_n_o(rts_n), .serial_tx_out_o(serial_tx_out),
      .tx_dma_ready_n_o(dma_n), .modem_event_o(mod_ev));

   uaf_remote #(.BIT_CYCLES(4)) i_uaf_remote (
      .mclk_i(mclk), .line_i(serial_tx_out), .rts_n_i(rts_n),
      .rx_ready_i(rx_ready), .send_en_i(send_en), .cts_hold_i(cts_hold),
      .cts_n_o(cts_n), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .got_o(got), .got_cnt_o(got_cnt));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic pause(input int c);
      repeat (c) begin
         @(posedge mclk);
         #1;
      end
   endtask : pause

   // Unused strobe always held inactive
   task automatic wrx(input logic [2:0] a, input logic [7:0] v,
                      input logic s, input logic p);
      bus_addr <= a;
      bus_wdata <= v;
      bus_sel <= s;
      wr_p <= p;
      wr_n <= p;
      pause(1);
      bus_sel <= 1'b0;
      wr_p <= 1'b0;
      wr_n <= 1'b1;
      pause(1);
   endtask : wrx

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      wrx(a, v, 1'b1, 1'b0);
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      bus_addr <= a;
      bus_rd <= 1'b1;
      pause(1);
      bus_rd <= 1'b0;
      v = bus_rdata;
      pause(1);
   endtask : rd

   task automatic give_verdict();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      checked = 0;
      err_total = 0;
      arst_n = 1'b0;
      bus_addr = '0;
      bus_wdata = 8'h00;
      bus_sel = 1'b0;
      wr_n = 1'b1;
      wr_p = 1'b0;
      bus_rd = 1'b0;
      send_en = 1'b0;
      // Pin starts inactive, matching the synchroniser reset value
      cts_hold = 1'b1;
      rx_exp = 8'h00;
      trig_fcr = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h21, 8'h61, 8'hA1, 8'hE1};
      trig_lvl = '{`UAF_TRIG16_0, `UAF_TRIG16_1, `UAF_TRIG16_2,
                   `UAF_TRIG16_3, `UAF_TRIG64_0, `UAF_TRIG64_1,
                   `UAF_TRIG64_2, `UAF_TRIG64_3};
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      pause(2);
      `CHK("serial_tx_out_rst", 1'b1, serial_tx_out)
      `CHK("rts_rst", 1'b1, rts_n)
      rd(`UAF_OFS_MCR, d);
      `CHK("mcr_rst", `UAF_MCR_RESET, d)
      wrx(`UAF_OFS_MCR, 8'h02, 1'b0, 1'b1);
      rd(`UAF_OFS_MCR, d);
      `CHK("mcr_unsel", 8'h00, d)
      wrx(`UAF_OFS_MCR, 8'h02, 1'b1, 1'b1);
      rd(`UAF_OFS_MCR, d);
      `CHK("mcr_wrp", 8'h02, d)
      `CHK("rts_bit1", 1'b0, rts_n)
      wr(`UAF_OFS_MCR, 8'h12);
      rd(`UAF_OFS_MCR, d);
      `CHK("mcr_wrn", 8'h12, d)
      `CHK("rts_loop", 1'b1, rts_n)
      `CHK("serial_tx_out_loop", 1'b1, serial_tx_out)
      wr(3'h7, 8'hFF);
      rd(3'h7, d);
      `CHK("unmapped", 8'h00, d)
      $display("test reset_bus done");

      wr(`UAF_OFS_MCR, 8'h22);
      for (int t = 0; t < 8; t++) begin
         wr(`UAF_OFS_FCR, trig_fcr[t]);
         pause(3);
         `CHK("rts_open", 1'b0, rts_n)
         send_en <= 1'b1;
         `WAITC("rts_shut", rts_n, 300)
         send_en <= 1'b0;
         pause(4);
         rd(`UAF_OFS_RXLEVEL, d);
         `CHK("rx_level", {1'b0, trig_lvl[t]} + 8'h01, d)
         n = d;
         for (int i = 0; i < n; i++) begin
            rd(`UAF_OFS_DATA, d);
            `CHK("rx_byte", rx_exp, d)
            rx_exp = rx_exp + 8'h01;
            if (i == n - 2) `CHK("rts_hold", 1'b1, rts_n)
         end
         pause(3);
         `CHK("rts_back", 1'b0, rts_n)
      end
      $display("test auto_rts done");

      cts_hold <= 1'b1;
      wr(`UAF_OFS_FCR, 8'h09);
      pause(4);
      `CHK("dma1_empty", 1'b0, dma_n)
      for (int i = 0; i < 8; i++) wr(`UAF_OFS_DATA, 8'hA0 + 8'(i));
      pause(60);
      `CHK("dma1_full", 1'b1, dma_n)
      `CHK("tx_held", 8'h00, got_cnt)
      cts_hold <= 1'b0;
      `WAITC("tx_start", (serial_tx_out === 1'b0), 40)
      cts_hold <= 1'b1;
      pause(120);
      `CHK("one_byte", 8'h01, got_cnt)
      `CHK("byte0", 8'hA0, got)
      cts_hold <= 1'b0;
      `WAITC("tx_rest", (got_cnt === 8'h08), 600)
      `CHK("byte7", 8'hA7, got)
      $display("test auto_cts done");

      cts_hold <= 1'b1;
      wr(`UAF_OFS_FCR, 8'h01);
      wr(`UAF_OFS_DATA, 8'h5A);
      pause(4);
      `CHK("dma0_queued", 1'b1, dma_n)
      `CHK("no_event", 1'b0, mod_ev)
      wr(`UAF_OFS_MCR, 8'h02);
      `WAITC("tx_free", (got_cnt === 8'h09), 120)
      `CHK("byte_free", 8'h5A, got)
      `CHK("dma0_empty", 1'b0, dma_n)
      cts_hold <= 1'b0;
      pause(5);
      `CHK("cts_event", 1'b1, mod_ev)
      rd(`UAF_OFS_STATUS, d);
      `CHK("event_bit", 1'b1, d[`UAF_ST_CTS_DELTA])
      pause(1);
      `CHK("event_clr", 1'b0, mod_ev)
      wr(`UAF_OFS_FCR, 8'h00);
      wr(`UAF_OFS_MCR, 8'h20);
      cts_hold <= 1'b1;
      pause(4);
      `CHK("rts_char", 1'b1, rts_n)
      wr(`UAF_OFS_DATA, 8'hC3);
      `WAITC("tx_char", (got_cnt === 8'h0A), 120)
      `CHK("byte_char", 8'hC3, got)
      $display("test flow_off done");
      give_verdict();
   end
endmodule : tb_top

`default_nettype wire
